// *** pkg/trace_ctl_defines.vh ***
// constants for the trace control register bank
`ifndef TRACE_CTL_DEFINES_VH
`define TRACE_CTL_DEFINES_VH
// access selectors
`define ACC_FILTER      2'h0
`define ACC_BUFFER      2'h1
`define ACC_DATA        2'h2
`define BUF_CTL_OFFSET  16'h3008
// filter control fields
`define FC_SUPPORTED_TRACE_TYPE_HI    25
`define FC_SUPPORTED_TRACE_TYPE_LO    24
`define FC_ADW          23
`define FC_SYP_HI       22
`define FC_SYP_LO       20
`define FC_TB           19
`define FC_IO           18
`define FC_DBG          17
`define FC_EXC          16
`define FC_SUP          15
`define FC_KER          14
`define FC_USR          13
`define FC_PID_HI       12
`define FC_PID_LO       5
`define FC_GLOB         4
`define FC_FCR          3
`define FC_DMISS        2
`define FC_IMISS        1
`define FC_ON           0
`define FC_RW_MASK      32'h00FF_FFFF
// buffer control fields
`define BC_WE           31
`define BC_SRCW_HI      27
`define BC_SRCW_LO      26
`define BC_REG_HI       25
`define BC_REG_LO       21
`define BC_WR           20
`define BC_LOCK         18
`define BC_RM           16
`define BC_TR           15
`define BC_BF           14
`define BC_TM_HI        13
`define BC_TM_LO        12
// indirect register indices
`define IDX_CONFIG      5'h00
`define IDX_TW          5'h04
`define IDX_RDP         5'h05
`define IDX_WRP         5'h06
`define IDX_STP         5'h07
`define IDX_CFG0        5'h00
`define TM_WRAP         2'h0
`define TM_FROM         2'h1
`define SYP_BASE        4'h5
`endif

// *** rtl/trace_pointer.v ***
// one trace memory pointer with load, increment and clear
`timescale 1ns/1ps
module trace_pointer #(
  parameter AW = 8
) (
  // clock and reset
  input  wire          i_clk,
  input  wire          i_rst,
  // controls, clear has priority over load over increment
  input  wire          i_clr,
  input  wire          i_load,
  input  wire [AW-1:0] i_load_val,
  input  wire          i_inc,
  // value
  output reg  [AW-1:0] o_val
);
  always @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      o_val <= {AW{1'b0}};
    end else if (i_load) begin
      o_val <= i_load_val;
    end else if (i_inc) begin
      o_val <= o_val + {{(AW-1){1'b0}}, 1'b1};  // wraps at top of memory
    end
  end
endmodule // trace_pointer

// *** rtl/trace_control_registers.v ***
// trace control unit: filter and buffer control registers with on-chip trace memory
`timescale 1ns/1ps
`include "trace_ctl_defines.vh"
module trace_control_registers #(
  parameter       AW          = 8,
  parameter [1:0] VALID_MODES = 2'h2,
  parameter [1:0] SRC_WIDTH   = 2'h1,
  parameter       PROBE       = 1
) (
  // clock and reset
  input  wire        I_REF_CLK,
  input  wire        I_SYS_RST,
  // host register access, one-cycle strobes
  input  wire        i_acc_wr,
  input  wire        i_acc_rd,
  input  wire [1:0]  i_acc_sel,
  input  wire [31:0] i_acc_wdata,
  output reg  [31:0] o_acc_rdata,
  output reg         o_acc_rvalid,
  // trace words arriving from the core
  input  wire        i_tw_valid,
  input  wire [63:0] i_tw_data,
  // trace inputs to the core
  output reg         o_trace_on,
  output reg         o_global_proc,
  output reg  [7:0]  o_process_id_compare,
  output reg         o_user_en,
  output reg         o_kernel_en,
  output reg         o_supervisor_en,
  output reg         o_exception_en,
  output reg         o_debug_en,
  output reg         o_inhibit_overflow,
  output reg         o_all_branches,
  output reg  [2:0]  o_sync_period,
  output reg         o_function_call_trace,
  output reg         o_data_miss_trace,
  output reg         o_instruction_miss_trace,
  // buffer status
  output reg         o_buffer_full
);
  localparam DEPTH = 1 << AW;
  reg  [31:0] filt_r;
  reg  [4:0]  reg_sel_r;
  reg         wr_en_r;
  reg         lock_r;
  reg         rm_r;
  reg         tr_r;
  reg         bf_r;
  reg  [1:0]  tm_r;
  reg  [63:0] mem [0:DEPTH-1];
  reg  [63:0] tw_q;
  wire [AW-1:0] rdp;
  wire [AW-1:0] wrp;
  wire [AW-1:0] stp;
  wire        buf_wr  = i_acc_wr && i_acc_sel == `ACC_BUFFER && i_acc_wdata[`BC_WE];
  wire        dat_wr  = i_acc_wr && i_acc_sel == `ACC_DATA && wr_en_r;
  wire        dat_rd  = i_acc_rd && i_acc_sel == `ACC_DATA;
  wire        tw_rd   = dat_rd && reg_sel_r == `IDX_TW && !lock_r && rm_r;
  wire        ptr_wr  = dat_wr && !lock_r;
  wire        rm_set  = buf_wr && i_acc_wdata[`BC_RM] && !rm_r;
  wire        tr_go   = buf_wr && i_acc_wdata[`BC_TR];
  wire [AW-1:0] wrp_n = wrp + {{(AW-1){1'b0}}, 1'b1};
  wire        fill_md = tm_r == `TM_FROM;
  // store stops once full in fill mode; wrap mode keeps overwriting
  wire        tw_st   = i_tw_valid && !tr_r && !(fill_md && bf_r);
  wire        rdp_last = (rdp + {{(AW-1){1'b0}}, 1'b1}) == wrp;

  trace_pointer #(.AW(AW)) u_rdp (
    .i_clk(I_REF_CLK), .i_rst(I_SYS_RST), .i_clr(tr_r),
    .i_load(rm_set || (ptr_wr && reg_sel_r == `IDX_RDP)),
    .i_load_val(rm_set ? stp : i_acc_wdata[AW-1:0]),
    .i_inc(tw_rd), .o_val(rdp));
  trace_pointer #(.AW(AW)) u_wrp (
    .i_clk(I_REF_CLK), .i_rst(I_SYS_RST), .i_clr(tr_r),
    .i_load(ptr_wr && reg_sel_r == `IDX_WRP), .i_load_val(i_acc_wdata[AW-1:0]),
    .i_inc(tw_st), .o_val(wrp));
  trace_pointer #(.AW(AW)) u_stp (
    .i_clk(I_REF_CLK), .i_rst(I_SYS_RST), .i_clr(tr_r),
    .i_load(ptr_wr && reg_sel_r == `IDX_STP), .i_load_val(i_acc_wdata[AW-1:0]),
    .i_inc(1'b0), .o_val(stp));

  always @(posedge I_REF_CLK) begin
    if (tw_st) begin
      mem[wrp] <= i_tw_data;
    end
    tw_q <= mem[rdp];
  end

  // filter register and its core-facing copies
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      filt_r <= 32'h0000_0000;
    end else if (i_acc_wr && i_acc_sel == `ACC_FILTER) begin
      filt_r <= i_acc_wdata & `FC_RW_MASK;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      o_trace_on               <= 1'b0;
      o_global_proc            <= 1'b0;
      o_process_id_compare     <= 8'h00;
      o_user_en                <= 1'b0;
      o_kernel_en              <= 1'b0;
      o_supervisor_en          <= 1'b0;
      o_exception_en           <= 1'b0;
      o_debug_en               <= 1'b0;
      o_inhibit_overflow       <= 1'b0;
      o_all_branches           <= 1'b0;
      o_sync_period            <= 3'h0;
      o_function_call_trace    <= 1'b0;
      o_data_miss_trace        <= 1'b0;
      o_instruction_miss_trace <= 1'b0;
    end else begin
      // presented every cycle so the core sees a write with no handshake
      o_trace_on               <= filt_r[`FC_ON];
      o_global_proc            <= filt_r[`FC_GLOB];
      o_process_id_compare     <= filt_r[`FC_PID_HI:`FC_PID_LO];
      o_user_en                <= filt_r[`FC_USR];
      o_kernel_en              <= filt_r[`FC_KER];
      o_supervisor_en          <= filt_r[`FC_SUP];
      o_exception_en           <= filt_r[`FC_EXC];
      o_debug_en               <= filt_r[`FC_DBG];
      o_inhibit_overflow       <= filt_r[`FC_IO];
      o_all_branches           <= filt_r[`FC_TB];
      o_sync_period            <= filt_r[`FC_SYP_HI:`FC_SYP_LO];
      o_function_call_trace    <= filt_r[`FC_FCR];
      o_data_miss_trace        <= filt_r[`FC_DMISS];
      o_instruction_miss_trace <= filt_r[`FC_IMISS];
    end
  end

  // buffer control register
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      reg_sel_r <= 5'h00;
      wr_en_r   <= 1'b0;
      lock_r    <= 1'b0;
      rm_r      <= 1'b0;
      tr_r      <= 1'b0;
      bf_r      <= 1'b0;
      tm_r      <= 2'h0;
    end else begin
      tr_r <= tr_go;
      if (buf_wr) begin
        reg_sel_r <= i_acc_wdata[`BC_REG_HI:`BC_REG_LO];
        wr_en_r   <= i_acc_wdata[`BC_WR];
        lock_r    <= (PROBE != 0) && i_acc_wdata[`BC_LOCK];
        tm_r      <= i_acc_wdata[`BC_TM_HI:`BC_TM_LO];
      end
      if (tr_r) begin
        rm_r <= 1'b0;
        bf_r <= 1'b0;
      end else begin
        if (rm_set && stp != wrp) begin
          rm_r <= 1'b1;
        end else if (tw_rd && rdp_last) begin
          rm_r <= 1'b0;
        end
        // full when the write pointer comes round to the start pointer
        if (fill_md && tw_st && wrp_n == stp) begin
          bf_r <= 1'b1;
        end
      end
    end
  end

  // read data; trace word comes from the memory one cycle after the address settles
  reg        rd_pend_r;
  reg [1:0]  rd_sel_r;
  reg        rd_tw_r;
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      rd_pend_r <= 1'b0;
      rd_sel_r  <= 2'h0;
      rd_tw_r   <= 1'b0;
    end else begin
      rd_pend_r <= i_acc_rd;
      rd_sel_r  <= i_acc_sel;
      rd_tw_r   <= tw_rd;
    end
  end

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (rd_sel_r)
      `ACC_FILTER: begin
        rd_nxt = filt_r;
        rd_nxt[`FC_SUPPORTED_TRACE_TYPE_HI:`FC_SUPPORTED_TRACE_TYPE_LO] = VALID_MODES;
      end
      `ACC_BUFFER: begin
        // write-gate bit always reads zero
        rd_nxt[`BC_SRCW_HI:`BC_SRCW_LO] = SRC_WIDTH;
        rd_nxt[`BC_REG_HI:`BC_REG_LO]   = reg_sel_r;
        rd_nxt[`BC_WR]                  = wr_en_r;
        rd_nxt[`BC_LOCK]                = lock_r;
        rd_nxt[`BC_RM]                  = rm_r;
        rd_nxt[`BC_TR]                  = tr_r;
        rd_nxt[`BC_BF]                  = bf_r;
        rd_nxt[`BC_TM_HI:`BC_TM_LO]     = tm_r;
      end
      `ACC_DATA: begin
        case (reg_sel_r)
          `IDX_TW:  rd_nxt = rd_tw_r ? tw_q[31:0] : 32'h0000_0000;
          `IDX_RDP: rd_nxt[AW-1:0] = rdp;
          `IDX_WRP: rd_nxt[AW-1:0] = wrp;
          `IDX_STP: rd_nxt[AW-1:0] = stp;
          default:  rd_nxt = 32'h0000_0000;
        endcase
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      o_acc_rdata   <= 32'h0000_0000;
      o_acc_rvalid  <= 1'b0;
      o_buffer_full <= 1'b0;
    end else begin
      o_acc_rdata   <= rd_pend_r ? rd_nxt : 32'h0000_0000;
      o_acc_rvalid  <= rd_pend_r;
      o_buffer_full <= bf_r;
    end
  end
endmodule // trace_control_registers

// *** testbench/trace_ctl_checker_assertions.sv ***
// port-level assertions for the trace control register bank
`timescale 1ns/1ps
module trace_ctl_checker #(
  parameter [1:0] VALID_MODES = 2'h2,
  parameter [1:0] SRC_WIDTH   = 2'h1
) (
  input wire        I_REF_CLK,
  input wire        I_SYS_RST,
  input wire        i_acc_wr,
  input wire        i_acc_rd,
  input wire [1:0]  i_acc_sel,
  input wire [31:0] i_acc_wdata,
  input wire [31:0] o_acc_rdata,
  input wire        o_acc_rvalid,
  input wire        o_trace_on,
  input wire [7:0]  o_process_id_compare,
  input wire        o_user_en,
  input wire        o_debug_en,
  input wire        o_all_branches,
  input wire [2:0]  o_sync_period,
  input wire        o_buffer_full
);
  wire        fw = i_acc_wr && (i_acc_sel == 2'h0);
  wire [31:0] cv = {9'h000, o_sync_period, o_all_branches, 1'b0, o_debug_en, 3'h0,
                    o_user_en, o_process_id_compare, 4'h0, o_trace_on};
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence ans_s;
    ##2 o_acc_rvalid;
  endsequence
  sequence fw_s;
    fw ##2 1'b1;
  endsequence
  rd_answer_a: assert property (i_acc_rd |-> ans_s)
    else $error("read strobe not answered two cycles later");
  rvalid_cause_a: assert property (o_acc_rvalid |-> $past(i_acc_rd, 2))
    else $error("read answer without a read strobe");
  rdata_idle_a: assert property (!o_acc_rvalid |-> o_acc_rdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  core_follow_a: assert property (fw_s |-> cv == ($past(i_acc_wdata, 2) & 32'h007A_3FE1))
    else $error("core trace inputs do not follow filter write");
  core_hold_a: assert property (!$past(fw, 2) |-> $stable(cv))
    else $error("core trace inputs changed without filter write");
  supported_trace_type_ro_a: assert property (o_acc_rvalid && $past(i_acc_sel, 2) == 2'h0 |->
    o_acc_rdata[31:24] == {6'h00, VALID_MODES}) else $error("filter read-only field wrong");
  srcw_ro_a: assert property (o_acc_rvalid && $past(i_acc_sel, 2) == 2'h1 |->
    o_acc_rdata[31:26] == {4'h0, SRC_WIDTH}) else $error("buffer read-only fields wrong");
  core_reset_a: assert property ($fell(I_SYS_RST) |-> cv == 32'h0000_0000 && !o_buffer_full)
    else $error("outputs not cleared by reset");
endmodule // trace_ctl_checker
bind trace_control_registers trace_ctl_checker #(.VALID_MODES(VALID_MODES),
  .SRC_WIDTH(SRC_WIDTH)) u_chk (.I_REF_CLK, .I_SYS_RST, .i_acc_wr, .i_acc_rd, .i_acc_sel,
  .i_acc_wdata, .o_acc_rdata, .o_acc_rvalid, .o_trace_on, .o_process_id_compare, .o_user_en,
  .o_debug_en, .o_all_branches, .o_sync_period, .o_buffer_full);

// *** testbench/trace_core_model.sv ***
// behavioural core trace port feeding trace words to the unit
`timescale 1ns/1ps
module trace_core_model (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_emit,
  input  wire        i_trace_on,
  output reg         o_valid,
  output reg  [63:0] o_data
);
  reg [31:0] seq_r;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= 64'h0;
      seq_r   <= 32'h0;
    end else if (i_emit && i_trace_on) begin
      o_valid <= 1'b1;
      o_data  <= {~seq_r, 32'hA500_0000 | seq_r};
      seq_r   <= seq_r + 32'h1;
    end else begin
      // scrambled so a stale word never looks like fresh data
      o_valid <= 1'b0;
      o_data  <= ~o_data;
    end
  end
endmodule // trace_core_model

// *** testbench/tb_trace_control_registers.sv ***
// self-checking bench for the trace control register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_trace_control_registers;
  localparam [1:0] VM = 2'h2;
  localparam [1:0] SW = 2'h1;
  reg clk, rst, wq, rq, eq;
  reg  [1:0]  sel;
  reg  [31:0] wd;
  wire [31:0] rdat;
  wire [63:0] twd;
  wire [7:0]  pid;
  wire [2:0]  sync_period;
  wire rv, twv, on, glob, usr, ker, sup, exc, dbg, io, ab, fcr, dm, im, full;
  wire [31:0] cv = {9'h000, sync_period, ab, io, dbg, exc, sup, ker, usr, pid, glob, fcr, dm, im, on};
  int checks = 0;
  int n_fail = 0;
  trace_control_registers #(.AW(4), .VALID_MODES(VM), .SRC_WIDTH(SW), .PROBE(1)) DUT (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .i_acc_wr(wq), .i_acc_rd(rq), .i_acc_sel(sel),
    .i_acc_wdata(wd), .o_acc_rdata(rdat), .o_acc_rvalid(rv), .i_tw_valid(twv),
    .i_tw_data(twd), .o_trace_on(on), .o_global_proc(glob), .o_process_id_compare(pid),
    .o_user_en(usr), .o_kernel_en(ker), .o_supervisor_en(sup), .o_exception_en(exc),
    .o_debug_en(dbg), .o_inhibit_overflow(io), .o_all_branches(ab), .o_sync_period(sync_period),
    .o_function_call_trace(fcr), .o_data_miss_trace(dm), .o_instruction_miss_trace(im),
    .o_buffer_full(full));
  trace_core_model core (.i_clk(clk), .i_rst(rst), .i_emit(eq), .i_trace_on(on),
    .o_valid(twv), .o_data(twd));
  function automatic [31:0] bc(input [4:0] r, input w, lk, rm, tr, input [1:0] tm);
    bc = {1'b1, 5'h00, r, w, 1'b0, lk, 1'b0, rm, tr, 1'b0, tm, 12'h000};
  endfunction
  task automatic wr(input [1:0] s, input [31:0] d);
    @(posedge clk);
    #1;
    sel = s;
    wd = d;
    wq = 1'b1;
    @(posedge clk);
    #1;
    wq = 1'b0;
  endtask
  task automatic rd(input [1:0] s, output [31:0] d);
    @(posedge clk);
    #1;
    sel = s;
    rq = 1'b1;
    @(posedge clk);
    #1;
    rq = 1'b0;
    // the answer stands only between the second and third edge after the request
    @(posedge clk);
    #1;
    `CHK("rvalid", 1'b1, rv)
    d = rdat;
  endtask
  task automatic emit(input int n);
    @(posedge clk);
    #1;
    eq = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    eq = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    reg [31:0] d;
    rd(2'h0, d);
    `CHK("filter reset", {6'h00, VM, 24'h00_0000}, d)
    rd(2'h1, d);
    `CHK("buffer reset", {4'h0, SW, 26'h000_0000}, d)
  endtask
  task automatic t_filter;
    reg [31:0] d;
    reg [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = (i << 20) | (32'h0000_2000 << (i % 7)) | 32'h0000_14B1 | (i << 1);
      wr(2'h0, v);
      repeat (2) @(posedge clk);
      #1;
      `CHK("core inputs", v, cv)
      rd(2'h0, d);
      `CHK("filter read", v | {6'h00, VM, 24'h00_0000}, d)
    end
  endtask
  task automatic t_gate;
    reg [31:0] d;
    wr(2'h1, 32'h03F0_0000);
    rd(2'h1, d);
    `CHK("ungated write", {4'h0, SW, 26'h000_0000}, d)
    wr(2'h1, bc(5'h06, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0));
    rd(2'h1, d);
    `CHK("select field", {4'h0, SW, 5'h06, 1'b1, 20'h0_0000}, d & 32'hFFF0_0000)
    wr(2'h2, 32'h0000_0009);
    rd(2'h2, d);
    `CHK("indirect write", 32'h0000_0009, d)
    wr(2'h1, bc(5'h06, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
    wr(2'h2, 32'h0000_0003);
    rd(2'h2, d);
    `CHK("read-only select", 32'h0000_0009, d)
    wr(2'h1, bc(5'h06, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0));
    wr(2'h2, 32'h0000_0005);
    rd(2'h2, d);
    `CHK("locked pointer", 32'h0000_0009, d)
  endtask
  task automatic t_mem;
    reg [31:0] d;
    wr(2'h1, bc(5'h06, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
    rd(2'h2, d);
    `CHK("pointer cleared", 32'h0000_0000, d)
    emit(3);
    rd(2'h2, d);
    `CHK("write pointer", 32'h0000_0003, d)
    wr(2'h1, bc(5'h04, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0));
    rd(2'h2, d);
    `CHK("locked word", 32'h0000_0000, d)
    rd(2'h1, d);
    `CHK("read memory set", 1'b1, d[16])
    wr(2'h1, bc(5'h04, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0));
    for (int k = 0; k < 3; k++) begin
      // a repeated read-memory write mid-buffer must not rewind the read pointer
      if (k == 1) wr(2'h1, bc(5'h04, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0));
      rd(2'h2, d);
      `CHK("trace word", 32'hA500_0000 + k, d)
    end
    rd(2'h2, d);
    `CHK("word past end", 32'h0000_0000, d)
    rd(2'h1, d);
    `CHK("read memory done", 1'b0, d[16])
  endtask
  task automatic t_full;
    reg [31:0] d;
    wr(2'h1, bc(5'h06, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1));
    emit(15);
    `CHK("not yet full", 1'b0, full)
    emit(1);
    `CHK("full", 1'b1, full)
    rd(2'h1, d);
    `CHK("full bit", 1'b1, d[14])
    wr(2'h1, bc(5'h06, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
    // the reset pulse clears the flag one edge late and the output copy one more
    repeat (2) @(posedge clk);
    #1;
    `CHK("full cleared", 1'b0, full)
    emit(20);
    `CHK("wrap not full", 1'b0, full)
    rd(2'h2, d);
    `CHK("wrapped pointer", 32'h0000_0004, d)
  endtask
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, wq, rq, eq, sel, wd} = {1'b1, 3'h0, 2'h0, 32'h0000_0000};
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_filter;
    t_gate;
    t_mem;
    t_full;
    end_of_test;
  end
  initial begin
    // whole run needs well under 1000 cycles
    #40000;
    n_fail++;
    end_of_test;
  end
endmodule // tb_trace_control_registers
